/* design/flash_suspend_resume_control.sv */
module flash_suspend_resume_control
  import flash_suspend_pkg::*;
#(
  parameter int ERASE_CYCLES    = ERASE_DEFAULT_CYCLES,
  parameter int PROGRAM_CYCLES  = PROGRAM_DEFAULT_CYCLES,
  parameter int ERS_HALT_CYCLES = ERS_SUSP_MAX_CYCLES / 2,
  parameter int PRG_HALT_CYCLES = PRG_SUSP_MAX_CYCLES / 2
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic sck_pin,
  input  wire logic cs_n_pin,
  input  wire logic mosi_pin,
  input  wire logic erase_start,
  input  wire logic program_start,
  output logic      miso,
  output logic      miso_oe,
  output logic      write_in_progress_flag,
  output logic      erase_suspended,
  output logic      program_suspended,
  output logic      erase_done,
  output logic      program_done
);

  op_state_t             state_reg,    state_next;
  logic [OP_CNT_W-1:0]   op_left_reg,  op_left_next;
  logic [HALT_CNT_W-1:0] halt_cnt_reg, halt_cnt_next;
  logic                  busy_next;
  logic                  ers_done_next;
  logic                  prg_done_next;
  logic                  opcode_valid;
  logic [7:0]            opcode;

  function automatic logic is_busy(input op_state_t st);
    is_busy = (st == ST_ERASING) || (st == ST_ERS_HALTING) ||
              (st == ST_PROGRAMMING) || (st == ST_PRG_HALTING);
  endfunction

  function automatic logic op_is(input logic valid, input logic [7:0] code, input logic [7:0] want);
    op_is = valid && (code == want);
  endfunction

  spi_opcode_rx u_rx (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .sck_pin      (sck_pin),
    .cs_n_pin     (cs_n_pin),
    .mosi_pin     (mosi_pin),
    .busy         (write_in_progress_flag),
    .miso         (miso),
    .miso_oe      (miso_oe),
    .opcode_valid (opcode_valid),
    .opcode       (opcode)
  );

  // A single progress counter serves both operations: while one is
  // suspended nothing else runs here, so its remaining count simply waits.
  always_comb begin
    state_next    = state_reg;
    op_left_next  = op_left_reg;
    halt_cnt_next = halt_cnt_reg;
    ers_done_next = 1'b0;
    prg_done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (erase_start) begin
          state_next   = ST_ERASING;
          op_left_next = OP_CNT_W'(ERASE_CYCLES - 1);
        end else if (program_start) begin
          state_next   = ST_PROGRAMMING;
          op_left_next = OP_CNT_W'(PROGRAM_CYCLES - 1);
        end
      end
      ST_ERASING: begin
        if (op_is(opcode_valid, opcode, OP_ERS_SUSPEND)) begin
          state_next    = ST_ERS_HALTING;
          halt_cnt_next = HALT_CNT_W'(ERS_HALT_CYCLES - 1);
        end else if (op_left_reg == '0) begin
          state_next    = ST_IDLE;
          ers_done_next = 1'b1;
        end else begin
          op_left_next = op_left_reg - OP_CNT_W'(1);
        end
      end
      ST_ERS_HALTING: begin
        if (halt_cnt_reg == '0) begin
          state_next = ST_ERS_SUSPENDED;
        end else begin
          halt_cnt_next = halt_cnt_reg - HALT_CNT_W'(1);
        end
      end
      ST_ERS_SUSPENDED: begin
        if (op_is(opcode_valid, opcode, OP_ERS_RESUME)) begin
          state_next = ST_ERASING;
        end
      end
      ST_PROGRAMMING: begin
        if (op_is(opcode_valid, opcode, OP_PRG_SUSPEND)) begin
          state_next    = ST_PRG_HALTING;
          halt_cnt_next = HALT_CNT_W'(PRG_HALT_CYCLES - 1);
        end else if (op_left_reg == '0) begin
          state_next    = ST_IDLE;
          prg_done_next = 1'b1;
        end else begin
          op_left_next = op_left_reg - OP_CNT_W'(1);
        end
      end
      ST_PRG_HALTING: begin
        if (halt_cnt_reg == '0) begin
          state_next = ST_PRG_SUSPENDED;
        end else begin
          halt_cnt_next = halt_cnt_reg - HALT_CNT_W'(1);
        end
      end
      ST_PRG_SUSPENDED: begin
        if (op_is(opcode_valid, opcode, OP_PRG_RESUME)) begin
          state_next = ST_PROGRAMMING;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Opcodes not named in the current state fall through untouched.
    busy_next = is_busy(state_next);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg              <= ST_IDLE;
      op_left_reg            <= '0;
      halt_cnt_reg           <= '0;
      write_in_progress_flag <= 1'b0;
      erase_suspended        <= 1'b0;
      program_suspended      <= 1'b0;
      erase_done             <= 1'b0;
      program_done           <= 1'b0;
    end else begin
      state_reg              <= state_next;
      op_left_reg            <= op_left_next;
      halt_cnt_reg           <= halt_cnt_next;
      write_in_progress_flag <= busy_next;
      erase_suspended        <= (state_next == ST_ERS_SUSPENDED);
      program_suspended      <= (state_next == ST_PRG_SUSPENDED);
      erase_done             <= ers_done_next;
      program_done           <= prg_done_next;
    end
  end

  // Cycles spent halting, for the latency checks only.
  logic [HALT_CNT_W-1:0] lat_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (srst || !(state_reg == ST_ERS_HALTING || state_reg == ST_PRG_HALTING)) begin
      lat_cnt_reg <= '0;
    end else begin
      lat_cnt_reg <= lat_cnt_reg + HALT_CNT_W'(1);
    end
  end

  AST_ERS_SUSPEND_TAKEN: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_ERASING && opcode_valid && opcode == OP_ERS_SUSPEND)
      |=> state_reg == ST_ERS_HALTING ##1 write_in_progress_flag)
    else $error("erase suspend opcode not taken");

  AST_ERS_RESUME_TAKEN: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_ERS_SUSPENDED && opcode_valid && opcode == OP_ERS_RESUME)
      |=> state_reg == ST_ERASING && write_in_progress_flag && !erase_suspended)
    else $error("erase resume opcode not taken");

  AST_PRG_SUSPEND_TAKEN: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_PROGRAMMING && opcode_valid && opcode == OP_PRG_SUSPEND)
      |=> state_reg == ST_PRG_HALTING)
    else $error("program suspend opcode not taken");

  AST_PRG_RESUME_TAKEN: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_PRG_SUSPENDED && opcode_valid && opcode == OP_PRG_RESUME)
      |=> state_reg == ST_PROGRAMMING && !program_suspended)
    else $error("program resume opcode not taken");

  AST_ERS_HALT_LATENCY: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_ERS_HALTING) |-> lat_cnt_reg < HALT_CNT_W'(ERS_SUSP_MAX_CYCLES))
    else $error("erase suspend latency exceeded");

  AST_PRG_HALT_LATENCY: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_PRG_HALTING) |-> lat_cnt_reg < HALT_CNT_W'(PRG_SUSP_MAX_CYCLES))
    else $error("program suspend latency exceeded");

  AST_SUSPENDED_READY: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(erase_suspended || program_suspended) |-> !write_in_progress_flag)
    else $error("busy still set while suspended");

  AST_STRAY_OPCODE_IGNORED: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_IDLE && opcode_valid && !erase_start && !program_start)
      |=> state_reg == ST_IDLE)
    else $error("suspend or resume acted with nothing to act on");

  AST_RESUME_KEEPS_PROGRESS: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_ERASING && $past(state_reg) == ST_ERS_SUSPENDED)
      |-> op_left_reg == $past(op_left_reg))
    else $error("erase progress lost across suspend");

endmodule // flash_suspend_resume_control

/* design/flash_suspend_pkg.sv */
package flash_suspend_pkg;

  localparam logic [7:0] OP_ERS_SUSPEND = 8'h75;
  localparam logic [7:0] OP_ERS_RESUME  = 8'h7A;
  localparam logic [7:0] OP_PRG_SUSPEND = 8'h85;
  localparam logic [7:0] OP_PRG_RESUME  = 8'h8A;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;

  localparam logic [2:0] STATUS_BUSY_BIT = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST   = 3'h7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ERS_SUSP_MAX_US = 48;
  localparam int PRG_SUSP_MAX_US = 40;
  // Longest times round down to whole clock cycles.
  localparam int ERS_SUSP_MAX_CYCLES = ERS_SUSP_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int PRG_SUSP_MAX_CYCLES = PRG_SUSP_MAX_US * 1000 / CLK_PERIOD_NS;

  localparam int ERASE_DEFAULT_CYCLES   = 100000;
  localparam int PROGRAM_DEFAULT_CYCLES = 20000;
  localparam int HALT_CNT_W = 16;
  localparam int OP_CNT_W   = 32;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASING,
    ST_ERS_HALTING,
    ST_ERS_SUSPENDED,
    ST_PROGRAMMING,
    ST_PRG_HALTING,
    ST_PRG_SUSPENDED
  } op_state_t;

endpackage

/* design/spi_opcode_rx.sv */
module spi_opcode_rx
  import flash_suspend_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       sck_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       mosi_pin,
  input  wire logic       busy,
  output logic            miso,
  output logic            miso_oe,
  output logic            opcode_valid,
  output logic [7:0]      opcode
);

  logic [1:0] sck_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic       sck_prev_reg;
  logic [2:0] bit_cnt_reg,  bit_cnt_next;
  logic [7:0] shift_reg,    shift_next;
  logic       got_op_reg,   got_op_next;
  logic       status_reg,   status_next;
  logic [2:0] out_cnt_reg,  out_cnt_next;
  logic       miso_next,    miso_oe_next;
  logic       opv_next;
  logic [7:0] opcode_next;
  logic       sck_rise;
  logic       sck_fall;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sck_sync_reg  <= 2'h0;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sck_prev_reg  <= 1'b0;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[0], sck_pin};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n_pin};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_pin};
      sck_prev_reg  <= sck_sync_reg[1];
    end
  end

  assign sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
  assign sck_fall = ~sck_sync_reg[1] & sck_prev_reg;

  // Mode 0 framing: data in on rising edges, status out on falling edges.
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    got_op_next  = got_op_reg;
    status_next  = status_reg;
    out_cnt_next = out_cnt_reg;
    miso_next    = miso;
    miso_oe_next = miso_oe;
    opv_next     = 1'b0;
    opcode_next  = opcode;
    if (cs_sync_reg[1]) begin
      bit_cnt_next = 3'h0;
      got_op_next  = 1'b0;
      status_next  = 1'b0;
      out_cnt_next = 3'h0;
      miso_oe_next = 1'b0;
      miso_next    = 1'b0;
    end else begin
      if (sck_rise && !got_op_reg) begin
        shift_next   = {shift_reg[6:0], mosi_sync_reg[1]};
        bit_cnt_next = bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == BIT_CNT_LAST) begin
          got_op_next = 1'b1;
          opv_next    = 1'b1;
          opcode_next = {shift_reg[6:0], mosi_sync_reg[1]};
          status_next = ({shift_reg[6:0], mosi_sync_reg[1]} == OP_READ_STATUS);
        end
      end
      if (sck_fall && status_reg) begin
        // Busy is re-sampled for every status byte so polling sees it drop.
        miso_next    = (out_cnt_reg == (BIT_CNT_LAST - STATUS_BUSY_BIT)) ? busy : 1'b0;
        miso_oe_next = 1'b1;
        out_cnt_next = out_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      got_op_reg   <= 1'b0;
      status_reg   <= 1'b0;
      out_cnt_reg  <= 3'h0;
      miso         <= 1'b0;
      miso_oe      <= 1'b0;
      opcode_valid <= 1'b0;
      opcode       <= 8'h00;
    end else begin
      bit_cnt_reg  <= bit_cnt_next;
      shift_reg    <= shift_next;
      got_op_reg   <= got_op_next;
      status_reg   <= status_next;
      out_cnt_reg  <= out_cnt_next;
      miso         <= miso_next;
      miso_oe      <= miso_oe_next;
      opcode_valid <= opv_next;
      opcode       <= opcode_next;
    end
  end

endmodule // spi_opcode_rx

/* sim/spi_host_model.sv */
module spi_host_model
  import flash_suspend_pkg::*;
(
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  // Erase and program keep their own resume time, so one never delays the other.
  realtime    resumed_at [2] = '{-1.0e9, -1.0e9};
  logic [7:0] rx_byte;
  event       op_sent;
  event       rx_done;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Sends one opcode, then clocks in n_rd bytes that the device drives on miso.
  // No array read is ever issued, so suspended contents are never looked at.
  task automatic frame(input logic [7:0] op, input int n_rd);
    int k;
    k = (op == OP_PRG_SUSPEND || op == OP_PRG_RESUME) ? 1 : 0;
    if ((op == OP_ERS_SUSPEND || op == OP_PRG_SUSPEND) && $realtime - resumed_at[k] < 128000.0) begin
      #(128000.0 - ($realtime - resumed_at[k]));
    end
    // Step off the caller's clock edge so no pin moves on that same edge.
    #1;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = op[i];
      #(HALF) sck = 1'b1;
      if (i == 0) ->op_sent;
      #(HALF) sck = 1'b0;
    end
    for (int b = 0; b < n_rd; b++) begin
      for (int i = 7; i >= 0; i--) begin
        mosi = ~mosi;
        #(HALF) sck = 1'b1;
        // An undriven line reads as unknown, so a missing enable cannot pass.
        rx_byte = {rx_byte[6:0], miso_oe ? miso : 1'bx};
        #(HALF) sck = 1'b0;
      end
      ->rx_done;
    end
    #(HALF) cs_n = 1'b1;
    mosi = ~mosi;
    if (op == OP_ERS_RESUME || op == OP_PRG_RESUME) resumed_at[k] = $realtime;
    #(4 * HALF);
  endtask
endmodule // spi_host_model

/* sim/tb_flash_suspend_resume_control.sv */
module tb_flash_suspend_resume_control;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_suspend_pkg::*;
  localparam int EC = 2000;
  localparam int PC = 1500;
  localparam int EH = 5;
  localparam int PH = 4;
  logic        sys_clk, srst, sck_pin, cs_n_pin, mosi_pin, erase_start, program_start;
  logic        miso, miso_oe, busy, erase_suspended, program_suspended, erase_done, program_done;
  logic        es_q, ps_q;
  logic [15:0] lfsr = 16'hB77C;
  logic [7:0]  ops [5];
  logic [7:0]  q_stat [$];
  int          q_kind [$], q_val [$], q_tol [$];
  int          n_errors = 0, n_compared = 0, cyc = 0, busy_cnt = 0, mark = 0;

  flash_suspend_resume_control #(.ERASE_CYCLES(EC), .PROGRAM_CYCLES(PC), .ERS_HALT_CYCLES(EH),
    .PRG_HALT_CYCLES(PH)) u_flash_suspend_resume_control (
    .sys_clk(sys_clk), .srst(srst), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin),
    .erase_start(erase_start), .program_start(program_start), .miso(miso), .miso_oe(miso_oe),
    .write_in_progress_flag(busy), .erase_suspended(erase_suspended),
    .program_suspended(program_suspended), .erase_done(erase_done), .program_done(program_done));

  spi_host_model u_spi_host_model (.sck(sck_pin), .cs_n(cs_n_pin), .mosi(mosi_pin), .miso(miso),
    .miso_oe(miso_oe));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input int tol);
    n_compared++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input int kind, input int val, input int tol);
    q_kind.push_back(kind);
    q_val.push_back(val);
    q_tol.push_back(tol);
  endtask

  task automatic take(input int kind, input logic [31:0] val);
    if (q_kind.size() == 0) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, kind, 0);
    end else begin
      compare(kind, q_kind.pop_front(), 0);
      compare(val, q_val.pop_front(), q_tol.pop_front());
    end
  endtask

  task automatic pulse(input int w);
    // The bench never starts work while anything is held suspended.
    if (erase_suspended === 1'b1 || program_suspended === 1'b1) return;
    @(posedge sys_clk);
    if (w != 0) program_start <= 1'b1;
    else erase_start <= 1'b1;
    @(posedge sys_clk);
    erase_start <= 1'b0;
    program_start <= 1'b0;
  endtask

  task automatic status(input logic [7:0] exp);
    q_stat.push_back(exp);
    q_stat.push_back(exp);
    u_spi_host_model.frame(OP_READ_STATUS, 2);
  endtask

  task automatic drain(input int max);
    for (int i = 0; i < max && q_kind.size() != 0; i++) @(posedge sys_clk);
    if (q_kind.size() != 0) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, q_kind.size(), 0);
      q_kind.delete();
      q_val.delete();
      q_tol.delete();
    end
  endtask

  task automatic print_verdict();
    $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(u_spi_host_model.op_sent) mark = cyc;

  always @(u_spi_host_model.rx_done) begin
    if (q_stat.size() == 0) take(0, 0);
    else compare(u_spi_host_model.rx_byte, q_stat.pop_front(), 0);
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    es_q <= erase_suspended;
    ps_q <= program_suspended;
    busy_cnt <= (srst || erase_done === 1'b1 || program_done === 1'b1) ? 0 : busy_cnt + 32'(busy === 1'b1);
    if (erase_done === 1'b1) take(1, busy_cnt);
    if (program_done === 1'b1) take(2, busy_cnt);
    if (erase_suspended === 1'b1 && es_q !== 1'b1) take(3, {busy, 16'(cyc - mark)});
    if (program_suspended === 1'b1 && ps_q !== 1'b1) take(4, {busy, 16'(cyc - mark)});
    if (cyc == 60000) begin
      n_errors++;
      $display("timeout at %0t", $time);
      print_verdict();
    end
  end

  initial begin
    srst = 1'b1;
    erase_start = 1'b0;
    program_start = 1'b0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    compare({busy, erase_suspended, program_suspended, erase_done, program_done, miso_oe}, 0, 0);
    $display("test reset done");
    for (int w = 0; w < 2; w++) begin
      note(1 + w, w ? PC : EC, 1);
      pulse(w);
      status(8'h01);
      drain(EC + 500);
      status(8'h00);
      $display("test plain run %0d done", w);
    end
    lfsr = lfsr_next(lfsr);
    ops = '{OP_ERS_SUSPEND, OP_ERS_RESUME, OP_PRG_SUSPEND, OP_PRG_RESUME, lfsr[7:0]};
    foreach (ops[i]) u_spi_host_model.frame(ops[i], 0);
    status(8'h00);
    compare({erase_suspended, program_suspended}, 0, 0);
    $display("test idle opcodes done");
    for (int w = 0; w < 2; w++) begin
      note(3 + w, (w ? PH : EH) + 5, 3);
      // Start late enough that the host never has to sit out a resume interval
      // before suspending, or the operation would finish before the suspend.
      while ($realtime - u_spi_host_model.resumed_at[w] < 128000.0) @(posedge sys_clk);
      pulse(w);
      lfsr = lfsr_next(lfsr);
      repeat (lfsr[5:0]) @(posedge sys_clk);
      u_spi_host_model.frame(w ? OP_PRG_SUSPEND : OP_ERS_SUSPEND, 0);
      drain(300);
      u_spi_host_model.frame(w ? OP_ERS_SUSPEND : OP_PRG_SUSPEND, 0);
      u_spi_host_model.frame(w ? OP_ERS_RESUME : OP_PRG_RESUME, 0);
      status(8'h00);
      compare({erase_suspended, program_suspended}, w ? 2'b01 : 2'b10, 0);
      note(1 + w, w ? PC + PH : EC + EH, 4);
      u_spi_host_model.frame(w ? OP_PRG_RESUME : OP_ERS_RESUME, 0);
      status(8'h01);
      drain(EC + 500);
      $display("test suspend %0d done", w);
    end
    print_verdict();
  end
endmodule // tb_flash_suspend_resume_control
